// File: hdl/charger_ctrl_pkg.sv
// shared constants for the charger control register bank
package charger_ctrl_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL_ONE = 8'h43;
	localparam logic [7:0] IDX_CONTROL_TWO = 8'h44;
	localparam logic [7:0] IDX_PRECHARGE_CUR = 8'h45;
	localparam logic [7:0] IDX_ADAPTER_FAST_CUR = 8'h46;
	localparam logic [7:0] IDX_USB_FAST_CUR = 8'h47;
	localparam logic [7:0] IDX_CUTOFF_CUR = 8'h48;
	localparam logic [7:0] IDX_USB_DIODE = 8'h49;
	localparam logic [7:0] IDX_THERM_SUSPEND = 8'h4A;
	localparam logic [7:0] IDX_MONITOR = 8'h50;

	// control one fields
	localparam int BIT_ENABLE = 0;
	localparam int BIT_AUTO_STOP = 1;
	localparam int BIT_AUTO_RESUME = 2;
	localparam int BIT_MAN_RESUME = 3;
	localparam int BIT_MAN_RESTART = 4;
	localparam int BIT_PRE_WD_LONG = 5;
	localparam int POS_FAST_WD = 6;
	// control two fields
	localparam int POS_COND_LEVEL = 0;
	localparam int POS_FLOAT_V = 2;
	localparam int BIT_DEBOUNCE_LONG = 7;
	// usb and diode fields
	localparam int POS_USB_STATUS = 0;
	localparam int BIT_TEMP_ENABLE = 2;
	localparam int POS_DIODE_LIMIT = 6;
	// thermistor and suspend fields
	localparam int POS_THERM_LEVEL = 0;
	localparam int BIT_SUSPEND_SWITCH = 4;

	// writable bit masks; everything else reads zero
	localparam logic [7:0] MASK_CONTROL_TWO = 8'hBF;
	localparam logic [7:0] MASK_CUTOFF = 8'h1F;
	localparam logic [7:0] MASK_USB_DIODE = 8'hC7;
	localparam logic [7:0] MASK_THERM = 8'h1F;

	// usb budget code that commands suspend
	localparam logic [1:0] USB_SUSPEND_CODE = 2'h3;

	// charger state machine mode codes
	localparam logic [3:0] MODE_USB_PRE = 4'h1;
	localparam logic [3:0] MODE_USB_PRE_WAIT = 4'h2;
	localparam logic [3:0] MODE_USB_FAST = 4'h3;
	localparam logic [3:0] MODE_USB_FAST_WAIT = 4'h4;
	localparam logic [3:0] MODE_ADP_PRE = 4'h6;
	localparam logic [3:0] MODE_ADP_PRE_WAIT = 4'h7;
	localparam logic [3:0] MODE_ADP_FAST = 4'h8;
	localparam logic [3:0] MODE_ADP_FAST_WAIT = 4'h9;
	localparam logic [3:0] MODE_FULL = 4'hA;
	localparam logic [3:0] MODE_HALT = 4'hB;

	// timing, in their own units
	localparam int CLK_HZ = 10_000_000;
	localparam int ONE_SECOND_S = 1;
	localparam int PRE_WD_SHORT_MIN = 30;
	localparam int PRE_WD_LONG_MIN = 60;
	localparam int FAST_WD_0_H = 1;
	localparam int FAST_WD_1_H = 2;
	localparam int FAST_WD_2_H = 4;
	localparam int FAST_WD_3_H = 6;
	localparam int DEBOUNCE_SHORT_S = 32;
	localparam int DEBOUNCE_LONG_S = 64;
	// derived counts
	localparam int SECOND_CYCLES = CLK_HZ * ONE_SECOND_S;
	localparam logic [14:0] PRE_WD_SHORT_S = 15'(PRE_WD_SHORT_MIN * 60);
	localparam logic [14:0] PRE_WD_LONG_S = 15'(PRE_WD_LONG_MIN * 60);
	localparam logic [14:0] FAST_WD_0_S = 15'(FAST_WD_0_H * 3600);
	localparam logic [14:0] FAST_WD_1_S = 15'(FAST_WD_1_H * 3600);
	localparam logic [14:0] FAST_WD_2_S = 15'(FAST_WD_2_H * 3600);
	localparam logic [14:0] FAST_WD_3_S = 15'(FAST_WD_3_H * 3600);
	localparam logic [14:0] DEBOUNCE_SHORT_CNT = 15'(DEBOUNCE_SHORT_S);
	localparam logic [14:0] DEBOUNCE_LONG_CNT = 15'(DEBOUNCE_LONG_S);
endpackage

// File: hdl/charger_control_registers.sv
// charger control register bank with ahb-lite slave and charge supervision
// Behaviour
// - enable clear blocks charging, detection keeps running
// - no auto-stop: end by disable or watchdog
// - auto-stop: end on low current in fast phases, or watchdog
// - auto-resume below 96 percent float voltage
// - manual resume from full, ignored under auto-resume
// - manual restart leaves halt mode
// - manual resume and restart self-clear when done
// - precharge watchdog 30 or 60 minutes
// - fast watchdog 1, 2, 4, 6 hours
// - condition level field sets precharge exit voltage
// - float voltage field, 20 mV steps
// - resume debounce 32 or 64 seconds
// - precharge and adapter currents scale code/255
// - usb fast current uses same scaling
// - cutoff current is (code+1)/32 of charge current
// - charge current code follows active mode
// - usb budget field, code 3 suspends
// - usb budget resets on standby entry
// - temperature enable gates temperature monitoring
// - diode current limit field 1.6 to 2.2 A
// - thermistor threshold field, 50 mV steps
// - suspend switch bit chooses switch or diode
module charger_control_registers #(
	parameter int SEC_CYCLES = charger_ctrl_pkg::SECOND_CYCLES,
	parameter logic [7:0] RST_CONTROL_ONE = 8'h00,
	parameter logic [7:0] RST_CONTROL_TWO = 8'h00,
	parameter logic [7:0] RST_PRECHARGE = 8'h00,
	parameter logic [7:0] RST_ADAPTER_FAST = 8'h00,
	parameter logic [7:0] RST_USB_FAST = 8'h00,
	parameter logic [7:0] RST_CUTOFF = 8'h00,
	parameter logic [7:0] RST_USB_DIODE = 8'h00,
	parameter logic [7:0] RST_THERM = 8'h00
) (
	input wire logic hclk, // bus clock
	input wire logic hresetn, // unpowered-state reset, low active
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic [3:0] charger_mode, // mode from charger state machine
	input wire logic standby_entry, // one-cycle pulse on standby entry
	input wire logic current_below_cutoff, // analog comparator pin
	input wire logic battery_below_resume, // analog comparator pin
	output logic charge_permit, // charging allowed
	output logic charge_stop_req, // end charging now
	output logic charge_resume_req, // leave full mode
	output logic charge_restart_req, // leave halt mode
	output logic precharge_wd_expired, // precharge time exceeded
	output logic fast_wd_expired, // fast charge time exceeded
	output logic [1:0] cond_level, // precharge exit voltage code
	output logic [3:0] float_voltage, // float voltage code
	output logic [7:0] charge_current_code, // code for active mode
	output logic [12:0] cutoff_threshold, // (code+1)*current, units iref/8160
	output logic [1:0] usb_budget, // usb input budget code
	output logic usb_suspend, // usb suspend commanded
	output logic temp_monitor_en, // battery temperature monitoring
	output logic [1:0] diode_current_limit, // battery-to-system limit code
	output logic [3:0] therm_high_level, // high-temperature threshold code
	output logic suspend_switch_on // usb-to-system switch in suspend
);
	import charger_ctrl_pkg::*;

	// elaboration-time refusal: the second divider needs at least two states
	if (SEC_CYCLES < 2) begin : g_bad_sec
		$error("SEC_CYCLES must be at least 2");
	end

	// software-visible storage
	logic [7:0] control_one_r;
	logic [7:0] control_two_r;
	logic [7:0] precharge_cur_r;
	logic [7:0] adapter_fast_cur_r;
	logic [7:0] usb_fast_cur_r;
	logic [7:0] cutoff_cur_r;
	logic [7:0] usb_diode_r;
	logic [7:0] therm_r;

	// bus pipeline
	logic wr_pend_r;
	logic rd_pend_r;
	logic [7:0] idx_r;
	logic addr_ok_r;
	logic take;
	logic wr_now;
	logic [7:0] wmask;

	// synchronised comparator pins
	logic [2:0] low_cur_sync_r;
	logic [2:0] below_res_sync_r;
	logic low_cur_r;
	logic below_res_r;

	// timing
	logic [$clog2(SEC_CYCLES)-1:0] tick_cnt_r;
	logic sec_tick_r;
	logic [14:0] pre_sec_r;
	logic [14:0] fast_sec_r;
	logic [14:0] deb_sec_r;
	logic [14:0] pre_limit;
	logic [14:0] fast_limit;
	logic [14:0] deb_limit;
	logic in_pre;
	logic in_fast;
	logic resume_ok;

	// transfer accepted in address phase; hsize is not checked, only word-aligned addresses are served
	assign take = hsel && htrans[1] && hready;
	assign wr_now = wr_pend_r && addr_ok_r;
	assign wmask = hwdata[7:0];

	// address phase capture; reads take one wait state so that a write
	// just before lands first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			idx_r <= 8'h00;
			addr_ok_r <= 1'b0;
		end else if (hreadyout) begin
			wr_pend_r <= take && hwrite;
			rd_pend_r <= take && !hwrite;
			idx_r <= haddr[9:2];
			addr_ok_r <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
		end else begin
			rd_pend_r <= 1'b0;
		end
	end

	// ready drops for the first data cycle of a read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else if (hreadyout && take && !hwrite) begin
			hreadyout <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// error response never used
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// read mux, unmapped and reserved bits give zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_pend_r) begin
			hrdata <= 32'h00000000;
			if (addr_ok_r) begin
				unique case (idx_r)
					IDX_CONTROL_ONE: hrdata[7:0] <= control_one_r;
					IDX_CONTROL_TWO: hrdata[7:0] <= control_two_r;
					IDX_PRECHARGE_CUR: hrdata[7:0] <= precharge_cur_r;
					IDX_ADAPTER_FAST_CUR: hrdata[7:0] <= adapter_fast_cur_r;
					IDX_USB_FAST_CUR: hrdata[7:0] <= usb_fast_cur_r;
					IDX_CUTOFF_CUR: hrdata[7:0] <= cutoff_cur_r;
					IDX_USB_DIODE: hrdata[7:0] <= usb_diode_r;
					IDX_THERM_SUSPEND: hrdata[7:0] <= therm_r;
					IDX_MONITOR: hrdata[7:0] <= {2'h0, below_res_r, low_cur_r,
						fast_wd_expired, precharge_wd_expired, charge_stop_req,
						charge_permit};
					default: hrdata[7:0] <= 8'h00;
				endcase
			end
		end
	end

	// control one; resume and restart self-clear, a write in the same
	// cycle wins so a fresh request is never lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_one_r <= RST_CONTROL_ONE;
		end else if (wr_now && idx_r == IDX_CONTROL_ONE) begin
			control_one_r <= wmask;
		end else begin
			if (charge_resume_req && charger_mode != MODE_FULL) begin
				control_one_r[BIT_MAN_RESUME] <= 1'b0;
			end
			if (charge_restart_req && charger_mode != MODE_HALT) begin
				control_one_r[BIT_MAN_RESTART] <= 1'b0;
			end
		end
	end

	// plain fields, reserved bits masked off on write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_two_r <= RST_CONTROL_TWO & MASK_CONTROL_TWO;
			precharge_cur_r <= RST_PRECHARGE;
			adapter_fast_cur_r <= RST_ADAPTER_FAST;
			usb_fast_cur_r <= RST_USB_FAST;
			cutoff_cur_r <= RST_CUTOFF & MASK_CUTOFF;
			therm_r <= RST_THERM & MASK_THERM;
		end else if (wr_now) begin
			if (idx_r == IDX_CONTROL_TWO) begin
				control_two_r <= wmask & MASK_CONTROL_TWO;
			end
			if (idx_r == IDX_PRECHARGE_CUR) begin
				precharge_cur_r <= wmask;
			end
			if (idx_r == IDX_ADAPTER_FAST_CUR) begin
				adapter_fast_cur_r <= wmask;
			end
			if (idx_r == IDX_USB_FAST_CUR) begin
				usb_fast_cur_r <= wmask;
			end
			if (idx_r == IDX_CUTOFF_CUR) begin
				cutoff_cur_r <= wmask & MASK_CUTOFF;
			end
			if (idx_r == IDX_THERM_SUSPEND) begin
				therm_r <= wmask & MASK_THERM;
			end
		end
	end

	// usb budget also returns to its reset value on standby entry;
	// standby wins over a write in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			usb_diode_r <= RST_USB_DIODE & MASK_USB_DIODE;
		end else begin
			if (wr_now && idx_r == IDX_USB_DIODE) begin
				usb_diode_r <= wmask & MASK_USB_DIODE;
			end
			if (standby_entry) begin
				usb_diode_r[POS_USB_STATUS +: 2] <= RST_USB_DIODE[POS_USB_STATUS +: 2];
			end
		end
	end

	// comparator pins: three stages, a change counts once two and three agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_cur_sync_r <= 3'h0;
			below_res_sync_r <= 3'h0;
			low_cur_r <= 1'b0;
			below_res_r <= 1'b0;
		end else begin
			low_cur_sync_r <= {low_cur_sync_r[1:0], current_below_cutoff};
			below_res_sync_r <= {below_res_sync_r[1:0], battery_below_resume};
			if (low_cur_sync_r[2] == low_cur_sync_r[1]) begin
				low_cur_r <= low_cur_sync_r[2];
			end
			if (below_res_sync_r[2] == below_res_sync_r[1]) begin
				below_res_r <= below_res_sync_r[2];
			end
		end
	end

	// one-second enable pulse; long watchdogs count seconds, not cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_r <= '0;
			sec_tick_r <= 1'b0;
		end else if (tick_cnt_r == ($clog2(SEC_CYCLES))'(SEC_CYCLES - 1)) begin
			tick_cnt_r <= '0;
			sec_tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			sec_tick_r <= 1'b0;
		end
	end

	// phase decode and limit selection
	assign in_pre = charger_mode == MODE_USB_PRE || charger_mode == MODE_USB_PRE_WAIT ||
		charger_mode == MODE_ADP_PRE || charger_mode == MODE_ADP_PRE_WAIT;
	assign in_fast = charger_mode == MODE_USB_FAST || charger_mode == MODE_USB_FAST_WAIT ||
		charger_mode == MODE_ADP_FAST || charger_mode == MODE_ADP_FAST_WAIT;
	assign pre_limit = control_one_r[BIT_PRE_WD_LONG] ? PRE_WD_LONG_S : PRE_WD_SHORT_S;
	assign deb_limit = control_two_r[BIT_DEBOUNCE_LONG] ? DEBOUNCE_LONG_CNT :
		DEBOUNCE_SHORT_CNT;

	// fast watchdog limit by two-bit code
	always_comb begin
		unique case (control_one_r[POS_FAST_WD +: 2])
			2'h0: fast_limit = FAST_WD_0_S;
			2'h1: fast_limit = FAST_WD_1_S;
			2'h2: fast_limit = FAST_WD_2_S;
			2'h3: fast_limit = FAST_WD_3_S;
		endcase
	end

	// precharge watchdog: runs only in precharge phases, sticky until exit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_sec_r <= 15'h0000;
			precharge_wd_expired <= 1'b0;
		end else if (!in_pre) begin
			pre_sec_r <= 15'h0000;
			precharge_wd_expired <= 1'b0;
		end else if (sec_tick_r && !precharge_wd_expired) begin
			pre_sec_r <= pre_sec_r + 15'h0001;
			if (pre_sec_r + 15'h0001 >= pre_limit) begin
				precharge_wd_expired <= 1'b1;
			end
		end
	end

	// fast-charge watchdog, same scheme in fast phases
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_sec_r <= 15'h0000;
			fast_wd_expired <= 1'b0;
		end else if (!in_fast) begin
			fast_sec_r <= 15'h0000;
			fast_wd_expired <= 1'b0;
		end else if (sec_tick_r && !fast_wd_expired) begin
			fast_sec_r <= fast_sec_r + 15'h0001;
			if (fast_sec_r + 15'h0001 >= fast_limit) begin
				fast_wd_expired <= 1'b1;
			end
		end
	end

	// resume debounce: comparator must stay low-battery for the whole time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deb_sec_r <= 15'h0000;
		end else if (!below_res_r || charger_mode != MODE_FULL) begin
			deb_sec_r <= 15'h0000;
		end else if (sec_tick_r && deb_sec_r < deb_limit) begin
			deb_sec_r <= deb_sec_r + 15'h0001;
		end
	end
	assign resume_ok = deb_sec_r >= deb_limit;

	// enable, stop conditions
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			charge_permit <= 1'b0;
			charge_stop_req <= 1'b0;
		end else begin
			charge_permit <= control_one_r[BIT_ENABLE];
			// watchdog ends charging whether or not auto-stop is on
			charge_stop_req <= !control_one_r[BIT_ENABLE] ||
				precharge_wd_expired || fast_wd_expired ||
				(control_one_r[BIT_AUTO_STOP] && in_fast && low_cur_r);
		end
	end

	// resume and restart requests; held until the mode moves on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			charge_resume_req <= 1'b0;
			charge_restart_req <= 1'b0;
		end else begin
			charge_resume_req <= charger_mode == MODE_FULL && control_one_r[BIT_ENABLE] &&
				(control_one_r[BIT_AUTO_RESUME] ? resume_ok :
				control_one_r[BIT_MAN_RESUME]);
			charge_restart_req <= charger_mode == MODE_HALT && control_one_r[BIT_ENABLE] &&
				control_one_r[BIT_MAN_RESTART];
		end
	end

	// charge current follows the active phase; cutoff is (code+1)/32 of it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			charge_current_code <= 8'h00;
			cutoff_threshold <= 13'h0000;
		end else begin
			if (in_pre) begin
				charge_current_code <= precharge_cur_r;
			end else if (charger_mode == MODE_USB_FAST || charger_mode == MODE_USB_FAST_WAIT) begin
				charge_current_code <= usb_fast_cur_r;
			end else begin
				charge_current_code <= adapter_fast_cur_r;
			end
			cutoff_threshold <= 13'((14'(cutoff_cur_r[4:0]) + 14'h0001) *
				14'(charge_current_code));
		end
	end

	// analog-facing fields copied to flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cond_level <= 2'h0;
			float_voltage <= 4'h0;
			usb_budget <= 2'h0;
			usb_suspend <= 1'b0;
			temp_monitor_en <= 1'b0;
			diode_current_limit <= 2'h0;
			therm_high_level <= 4'h0;
			suspend_switch_on <= 1'b0;
		end else begin
			cond_level <= control_two_r[POS_COND_LEVEL +: 2];
			float_voltage <= control_two_r[POS_FLOAT_V +: 4];
			usb_budget <= usb_diode_r[POS_USB_STATUS +: 2];
			usb_suspend <= usb_diode_r[POS_USB_STATUS +: 2] == USB_SUSPEND_CODE;
			temp_monitor_en <= usb_diode_r[BIT_TEMP_ENABLE];
			diode_current_limit <= usb_diode_r[POS_DIODE_LIMIT +: 2];
			therm_high_level <= therm_r[POS_THERM_LEVEL +: 4];
			suspend_switch_on <= therm_r[BIT_SUSPEND_SWITCH];
		end
	end
endmodule

// File: verification/charger_control_registers_monitor.sv
// port-level assertions for the charger control register bank
module charger_control_registers_monitor (
	input wire logic hclk, // clock
	input wire logic hresetn, // reset, low active
	input wire logic hsel, // select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic [2:0] hsize, // size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	input wire logic [31:0] hrdata, // read data
	input wire logic hreadyout, // slave ready
	input wire logic hresp, // response
	input wire logic [3:0] charger_mode, // mode
	input wire logic standby_entry, // standby pulse
	input wire logic current_below_cutoff, // pin
	input wire logic battery_below_resume, // pin
	input wire logic charge_permit, // permit
	input wire logic charge_stop_req, // stop
	input wire logic charge_resume_req, // resume
	input wire logic charge_restart_req, // restart
	input wire logic precharge_wd_expired, // timeout
	input wire logic fast_wd_expired, // timeout
	input wire logic [1:0] cond_level, // field
	input wire logic [3:0] float_voltage, // field
	input wire logic [7:0] charge_current_code, // code
	input wire logic [12:0] cutoff_threshold, // threshold
	input wire logic [1:0] usb_budget, // field
	input wire logic usb_suspend, // suspend
	input wire logic temp_monitor_en, // field
	input wire logic [1:0] diode_current_limit, // field
	input wire logic [3:0] therm_high_level, // field
	input wire logic suspend_switch_on // field
);
	timeunit 1ns;
	timeprecision 1ns;
	import charger_ctrl_pkg::*;

	// one clock domain, everything quiet in reset
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// bus steps: a taken request, then the read wait state
	sequence s_take;
		hsel && htrans[1] && hready;
	endsequence
	sequence s_rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence

	property p_read_wait;
		s_take ##0 !hwrite |=> s_rd_answer;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read answer out of step");
	property p_write_nowait;
		s_take ##0 hwrite |=> hreadyout;
	endproperty
	a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
	property p_upper_zero;
		hrdata[31:8] == 24'h0 && hresp == 1'b0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	// read data must not drift between reads
	property p_hold_data;
		hreadyout && $past(hreadyout) |-> $stable(hrdata);
	endproperty
	a_hold_data: assert property (p_hold_data) else $error("read data drifted");
	property p_disabled_stops;
		!charge_permit && $past(hresetn) |-> charge_stop_req;
	endproperty
	a_disabled_stops: assert property (p_disabled_stops) else $error("disabled but no stop");
	property p_resume_gate;
		charge_resume_req |-> $past(charger_mode) == MODE_FULL && charge_permit;
	endproperty
	a_resume_gate: assert property (p_resume_gate) else $error("resume outside full");
	property p_restart_gate;
		charge_restart_req |-> $past(charger_mode) == MODE_HALT && charge_permit;
	endproperty
	a_restart_gate: assert property (p_restart_gate) else $error("restart outside halt");
	// expiry may land one cycle ahead of the stop request
	property p_wd_stop;
		$rose(precharge_wd_expired) || $rose(fast_wd_expired) |-> ##[0:1] charge_stop_req;
	endproperty
	a_wd_stop: assert property (p_wd_stop) else $error("timeout without stop");
	property p_suspend_code;
		usb_suspend == (usb_budget == USB_SUSPEND_CODE);
	endproperty
	a_suspend_code: assert property (p_suspend_code) else $error("suspend mismatch");
	property p_standby_budget;
		standby_entry |-> ##2 usb_budget == 2'h0;
	endproperty
	a_standby_budget: assert property (p_standby_budget) else $error("budget kept");
endmodule

bind charger_control_registers charger_control_registers_monitor u_mon (.*);

// File: verification/test_charger_control_registers.sv
// self-checking bench for the charger control register bank
module test_charger_control_registers;
	timeunit 1ns;
	timeprecision 1ns;
	import charger_ctrl_pkg::*;

	localparam int SEC = 4; // short seconds keep timeout runs brief
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, standby_entry = 1'b0;
	logic current_below_cutoff = 1'b0, battery_below_resume = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [3:0] charger_mode = 4'h0;
	logic hready, hreadyout, hresp, charge_permit, charge_stop_req;
	logic charge_resume_req, charge_restart_req, precharge_wd_expired, fast_wd_expired;
	logic usb_suspend, temp_monitor_en, suspend_switch_on;
	logic [31:0] hrdata, d;
	logic [3:0] float_voltage, therm_high_level;
	logic [1:0] cond_level, usb_budget, diode_current_limit;
	logic [7:0] charge_current_code;
	logic [12:0] cutoff_threshold;
	int n_fail = 0;
	int total_checks = 0;
	logic [7:0] masks [8] = '{8'hFF, MASK_CONTROL_TWO, 8'hFF, 8'hFF, 8'hFF, MASK_CUTOFF,
		MASK_USB_DIODE, MASK_THERM};
	logic [7:0] pats [2] = '{8'hFF, 8'hA5};
	logic [3:0] modes [5] = '{MODE_USB_PRE, MODE_USB_FAST, MODE_ADP_PRE, MODE_ADP_FAST, MODE_HALT};
	logic [7:0] codes [5] = '{8'h11, 8'h33, 8'h11, 8'h22, 8'h22};
	int hrs [2] = '{FAST_WD_0_H, FAST_WD_1_H};

	// single slave, so its ready is the bus ready
	assign hready = hreadyout;
	always #50 hclk = ~hclk;
	charger_control_registers #(.SEC_CYCLES(SEC)) u_dut (.*);

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// bounded wait for the slave to accept the current phase
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				n_fail++;
				finish_test();
			end
			@(posedge hclk);
		end
	endtask

	// one single-word transfer; read data lands in d
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		wait_rdy();
		d = hrdata;
	endtask

	// count cycles until a status output rises; the prescaler phase blurs the start
	task automatic measure(input int sel, input int exp_cyc);
		int n;
		logic s;
		n = 0;
		s = 1'b0;
		while (s !== 1'b1 && n < exp_cyc + 40) begin
			@(posedge hclk);
			n++;
			s = (sel == 0) ? precharge_wd_expired : (sel == 1) ? fast_wd_expired : charge_resume_req;
		end
		chk(32'(n + 8 >= exp_cyc && n <= exp_cyc + 12), 32'h1);
		if (s !== 1'b1) begin
			n_fail++;
			finish_test();
		end
	endtask

	// main sequence
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int k = 0; k < 8; k++) begin
			bus(IDX_CONTROL_ONE + 8'(k), 1'b0, 8'h0);
			chk(d, 32'h0);
		end
		foreach (pats[p]) begin
			for (int k = 0; k < 8; k++) bus(IDX_CONTROL_ONE + 8'(k), 1'b1, pats[p]);
			for (int k = 0; k < 8; k++) begin
				bus(IDX_CONTROL_ONE + 8'(k), 1'b0, 8'h0);
				chk(d, {24'h0, pats[p] & masks[k]});
			end
			chk(32'(cond_level), 32'(pats[p][POS_COND_LEVEL +: 2]));
			chk(32'(float_voltage), 32'(pats[p][POS_FLOAT_V +: 4]));
			chk(32'(usb_budget), 32'(pats[p][POS_USB_STATUS +: 2]));
			chk(32'(usb_suspend), 32'(pats[p][1:0] == USB_SUSPEND_CODE));
			chk(32'(temp_monitor_en), 32'(pats[p][BIT_TEMP_ENABLE]));
			chk(32'(diode_current_limit), 32'(pats[p][POS_DIODE_LIMIT +: 2]));
			chk(32'(therm_high_level), 32'(pats[p][POS_THERM_LEVEL +: 4]));
			chk(32'(suspend_switch_on), 32'(pats[p][BIT_SUSPEND_SWITCH]));
		end
		bus(8'h4B, 1'b1, 8'hFF);
		bus(8'h4B, 1'b0, 8'h0);
		chk(d, 32'h0);
		// current code follows the mode, cutoff scales it by four
		bus(IDX_PRECHARGE_CUR, 1'b1, 8'h11);
		bus(IDX_ADAPTER_FAST_CUR, 1'b1, 8'h22);
		bus(IDX_USB_FAST_CUR, 1'b1, 8'h33);
		bus(IDX_CUTOFF_CUR, 1'b1, 8'h03);
		foreach (modes[m]) begin
			charger_mode <= modes[m];
			repeat (3) @(posedge hclk);
			chk(32'(charge_current_code), 32'(codes[m]));
			chk(32'(cutoff_threshold), 32'(codes[m]) * 4);
		end
		// enable and automatic termination
		charger_mode <= MODE_ADP_FAST;
		current_below_cutoff <= 1'b1;
		bus(IDX_CONTROL_ONE, 1'b1, 8'h00);
		repeat (3) @(posedge hclk);
		chk(32'({charge_permit, charge_stop_req}), 32'h1);
		bus(IDX_CONTROL_ONE, 1'b1, 8'h01);
		repeat (3) @(posedge hclk);
		chk(32'({charge_permit, charge_stop_req}), 32'h2);
		bus(IDX_CONTROL_ONE, 1'b1, 8'h03);
		repeat (8) @(posedge hclk);
		chk(32'(charge_stop_req), 32'h1);
		// status word: permit, stop and synced low current set
		bus(IDX_MONITOR, 1'b0, 8'h0);
		chk(d, 32'h13);
		current_below_cutoff <= 1'b0;
		repeat (8) @(posedge hclk);
		chk(32'(charge_stop_req), 32'h0);
		// precharge limits, short then long
		for (int k = 0; k < 2; k++) begin
			charger_mode <= 4'h0;
			bus(IDX_CONTROL_ONE, 1'b1, 8'(k << BIT_PRE_WD_LONG) | 8'h01);
			charger_mode <= MODE_USB_PRE;
			measure(0, (k == 0 ? PRE_WD_SHORT_MIN : PRE_WD_LONG_MIN) * 60 * SEC);
			repeat (2) @(posedge hclk);
			chk(32'(charge_stop_req), 32'h1);
		end
		for (int k = 0; k < 2; k++) begin
			charger_mode <= 4'h0;
			bus(IDX_CONTROL_ONE, 1'b1, {2'(k), 6'h01});
			charger_mode <= MODE_USB_FAST;
			measure(1, hrs[k] * 3600 * SEC);
		end
		// automatic resume after each debounce length
		charger_mode <= MODE_FULL;
		for (int k = 0; k < 2; k++) begin
			battery_below_resume <= 1'b0;
			repeat (6) @(posedge hclk);
			bus(IDX_CONTROL_TWO, 1'b1, 8'(k << BIT_DEBOUNCE_LONG));
			bus(IDX_CONTROL_ONE, 1'b1, 8'h05);
			battery_below_resume <= 1'b1;
			measure(2, (k == 0 ? DEBOUNCE_SHORT_S : DEBOUNCE_LONG_S) * SEC);
		end
		battery_below_resume <= 1'b0;
		repeat (6) @(posedge hclk);
		bus(IDX_CONTROL_ONE, 1'b1, 8'h0D);
		repeat (6) @(posedge hclk);
		chk(32'(charge_resume_req), 32'h0);
		bus(IDX_CONTROL_ONE, 1'b1, 8'h09);
		repeat (3) @(posedge hclk);
		chk(32'(charge_resume_req), 32'h1);
		charger_mode <= 4'h0;
		repeat (3) @(posedge hclk);
		bus(IDX_CONTROL_ONE, 1'b0, 8'h0);
		chk(d, 32'h01);
		charger_mode <= MODE_HALT;
		bus(IDX_CONTROL_ONE, 1'b1, 8'h11);
		repeat (3) @(posedge hclk);
		chk(32'(charge_restart_req), 32'h1);
		charger_mode <= 4'h0;
		repeat (3) @(posedge hclk);
		bus(IDX_CONTROL_ONE, 1'b0, 8'h0);
		chk(d, 32'h01);
		// standby clears only the usb budget; power loss clears the rest
		bus(IDX_USB_DIODE, 1'b1, 8'hA5);
		standby_entry <= 1'b1;
		@(posedge hclk);
		standby_entry <= 1'b0;
		bus(IDX_USB_DIODE, 1'b0, 8'h0);
		chk(d, 32'h84);
		chk(32'(usb_budget), 32'h0);
		bus(IDX_CONTROL_TWO, 1'b0, 8'h0);
		chk(d, 32'h80);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(IDX_CONTROL_TWO, 1'b0, 8'h0);
		chk(d, 32'h0);
		finish_test();
	end
endmodule
